// *** pcc_pkg.sv ***
`default_nettype none
package pcc_pkg;

  // ********************************************************
  // Register bus
  // ********************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] A_RTC_TIMER = 8'h10;
  localparam logic [ADDR_W-1:0] A_RTC_RELOAD = 8'h14;
  localparam logic [ADDR_W-1:0] A_RTC_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] A_RTC_LOW = 8'h1c;

  // ********************************************************
  // Field layout
  // ********************************************************
  localparam int CTRL_SDD_SEL = 0;
  localparam int CTRL_FACT_LSB = 4;
  localparam int FACT_W = 4;
  localparam int ST_POR_FLAG = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_ON_SDD = 2;
  localparam int ST_RET_WAIT = 3;
  localparam int ST_HALT = 4;
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_RETURN = 1;
  localparam int IRQ_HALT = 2;
  localparam int RTC_W = 16;

  // ********************************************************
  // Reset values and counts
  // ********************************************************
  localparam logic [FACT_W-1:0] RST_SDD_FACTOR = 4'h1;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
  localparam logic [RTC_W-1:0] RTC_CLEAR = 16'h0000;
  localparam int LOCK_CNT_W = 12;
  localparam int LOCK_PERIODS = 2048;
  // Oscillator periods equal core clock cycles: the core runs on it
  localparam logic [LOCK_CNT_W-1:0] LOCK_CYCLES =
    LOCK_CNT_W'(LOCK_PERIODS);

  // ********************************************************
  // Clock path states
  // ********************************************************
  typedef enum logic [1:0] {
    PS_BASIC = 2'b00,
    PS_SDD = 2'b01,
    PS_RETURN = 2'b11
  } pcc_path_t;

endpackage
`default_nettype wire

// *** pcc_top.sv ***
// Functional notes
// R1: Readable flag shows one if power-on was detected, else zero.
// R2: With power-on detected, lock rises after 2048 oscillator periods.
// R3: Detected power-on clears RTC timer, reload and both counter halves.
// R4: From basic clocking, software may move the CPU onto the divider.
// R5: Return from divider to basic path completes only with lock set.
// R6: Failed detection with clock: lock never set, RTC left as it was.
// R7: Software may keep divider at factor one or two as a fallback.
// R8: Failed detection, no clock: divider selected, no supervision, halt.
// R9: Detector result sampled once at reset release, used for flag and lock.
`timescale 1ns/100ps
`default_nettype none
module pcc_top
  import pcc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic por_detect_i,
  input wire logic osc_present_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic irq_o,
  output logic osc_lock_o,
  output logic clk_path_sdd_o,
  output logic [FACT_W-1:0] sdd_factor_o,
  output logic osc_supervision_o,
  output logic cpu_halt_o
);

  // ********************************************************
  // Input synchronisers
  // ********************************************************
  logic [2:0] por_sync_q;
  logic [2:0] osc_sync_q;
  logic por_filt_q;
  logic osc_filt_q;

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      por_sync_q <= {por_sync_q[1:0], por_detect_i};
      osc_sync_q <= {osc_sync_q[1:0], osc_present_i};
    end
  end

  // Filtered levels; hold reset four edges so these are settled
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      if (por_sync_q[1] == por_sync_q[2]) begin
        por_filt_q <= por_sync_q[2];
      end
      if (osc_sync_q[1] == osc_sync_q[2]) begin
        osc_filt_q <= osc_sync_q[2];
      end
    end
  end

  // ********************************************************
  // Reset release and power-on flag
  // ********************************************************
  logic rst_q;
  logic release_w;
  logic por_flag_q;
  logic halt_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rst_q <= 1'b1;
    end else if (clk_en_i) begin
      rst_q <= 1'b0;
    end
  end

  assign release_w = rst_q & ~rst_i & clk_en_i;

  // Caught once at release, never from the live pin
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      por_flag_q <= 1'b0;
    end else if (release_w) begin
      por_flag_q <= por_filt_q; // [R9] [R1]
    end
  end

  // No detection and no oscillator: the core stops on the divider
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      halt_q <= 1'b0;
    end else if (release_w) begin
      halt_q <= ~por_filt_q & ~osc_filt_q; // [R8]
    end
  end

  // ********************************************************
  // Oscillator lock detector
  // ********************************************************
  logic [LOCK_CNT_W-1:0] lock_cnt_q;
  logic lock_q;
  logic lock_set_w;

  // Counter only runs after a detected power-on; stops at target
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_cnt_q <= '0;
    end else if (clk_en_i && por_flag_q && !rst_q &&
                 lock_cnt_q != LOCK_CYCLES) begin
      lock_cnt_q <= lock_cnt_q + 1'b1; // [R2]
    end
  end

  assign lock_set_w = clk_en_i & por_flag_q & ~lock_q &
                      (lock_cnt_q == LOCK_CYCLES);

  // Without detection the lock never rises, which strands the return
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_q <= 1'b0;
    end else if (lock_set_w) begin
      lock_q <= 1'b1; // [R2] [R6]
    end
  end

  // ********************************************************
  // Register write decode
  // ********************************************************
  logic wr_ctrl_w;
  logic wr_stat_w;
  logic wr_mask_w;
  logic [FACT_W-1:0] fact_q;
  logic [IRQ_W-1:0] mask_q;

  assign wr_ctrl_w = clk_en_i & wr_i & (addr_i == A_CTRL);
  assign wr_stat_w = clk_en_i & wr_i & (addr_i == A_IRQ_STAT);
  assign wr_mask_w = clk_en_i & wr_i & (addr_i == A_IRQ_MASK);

  // Divider factor; one or two is the safe fallback setting
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fact_q <= RST_SDD_FACTOR;
    end else if (wr_ctrl_w) begin
      fact_q <= wdata_i[CTRL_FACT_LSB +: FACT_W]; // [R7]
    end
  end

  // Interrupt mask; all sources masked out of reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_q <= RST_IRQ_MASK;
    end else if (wr_mask_w) begin
      mask_q <= wdata_i[IRQ_W-1:0];
    end
  end

  // ********************************************************
  // Clock path selection
  // ********************************************************
  pcc_path_t path_q;

  // Return waits on lock; a new divider request cancels the wait
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      path_q <= PS_BASIC;
    end else if (clk_en_i) begin
      if (halt_q) begin
        path_q <= PS_SDD; // [R8]
      end else begin
        unique case (path_q)
          PS_BASIC: begin
            if (wr_ctrl_w && wdata_i[CTRL_SDD_SEL]) begin
              path_q <= PS_SDD; // [R4]
            end
          end
          PS_SDD: begin
            if (wr_ctrl_w && !wdata_i[CTRL_SDD_SEL]) begin
              path_q <= PS_RETURN;
            end
          end
          PS_RETURN: begin
            if (wr_ctrl_w && wdata_i[CTRL_SDD_SEL]) begin
              path_q <= PS_SDD;
            end else if (lock_q) begin
              path_q <= PS_BASIC; // [R5]
            end
          end
          default: begin
            path_q <= PS_SDD;
          end
        endcase
      end
    end
  end

  // ********************************************************
  // Real-time clock registers
  // ********************************************************
  logic [RTC_W-1:0] rtc_q [4];
  logic [ADDR_W-1:0] rtc_addr_w [4];
  assign rtc_addr_w[0] = A_RTC_TIMER;
  assign rtc_addr_w[1] = A_RTC_RELOAD;
  assign rtc_addr_w[2] = A_RTC_HIGH;
  assign rtc_addr_w[3] = A_RTC_LOW;

  // Not reset by rst_i: only a detected power-on clears them
  for (genvar g = 0; g < 4; g++) begin : g_rtc
    always_ff @(posedge core_clk_i) begin
      if (release_w && por_filt_q) begin
        rtc_q[g] <= RTC_CLEAR; // [R3]
      end else if (!rst_i && clk_en_i && wr_i &&
                   addr_i == rtc_addr_w[g]) begin
        rtc_q[g] <= wdata_i[RTC_W-1:0];
      end
    end
  end

  // ********************************************************
  // Interrupt status
  // ********************************************************
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_ev_w;
  assign irq_ev_w[IRQ_LOCK] = lock_set_w;
  assign irq_ev_w[IRQ_RETURN] = clk_en_i & ~halt_q &
    (path_q == PS_RETURN) & lock_q &
    ~(wr_ctrl_w & wdata_i[CTRL_SDD_SEL]);
  assign irq_ev_w[IRQ_HALT] = release_w & ~por_filt_q & ~osc_filt_q;

  // Set beats a write-one-to-clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q &
                     ~(wr_stat_w ? wdata_i[IRQ_W-1:0] : '0)) |
                    irq_ev_w;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(irq_stat_q & mask_q);
    end
  end

  // ********************************************************
  // Read port
  // ********************************************************
  logic [DATA_W-1:0] rd_mux_w;

  // Unmapped offsets and reserved bits read zero
  always_comb begin
    rd_mux_w = '0;
    unique case (addr_i)
      A_CTRL: begin
        rd_mux_w[CTRL_SDD_SEL] = path_q[0];
        rd_mux_w[CTRL_FACT_LSB +: FACT_W] = fact_q;
      end
      A_STATUS: begin
        rd_mux_w[ST_POR_FLAG] = por_flag_q; // [R1]
        rd_mux_w[ST_LOCK] = lock_q;
        rd_mux_w[ST_ON_SDD] = path_q[0];
        rd_mux_w[ST_RET_WAIT] = (path_q == PS_RETURN);
        rd_mux_w[ST_HALT] = halt_q;
      end
      A_IRQ_STAT: rd_mux_w[IRQ_W-1:0] = irq_stat_q;
      A_IRQ_MASK: rd_mux_w[IRQ_W-1:0] = mask_q;
      A_RTC_TIMER: rd_mux_w[RTC_W-1:0] = rtc_q[0];
      A_RTC_RELOAD: rd_mux_w[RTC_W-1:0] = rtc_q[1];
      A_RTC_HIGH: rd_mux_w[RTC_W-1:0] = rtc_q[2];
      A_RTC_LOW: rd_mux_w[RTC_W-1:0] = rtc_q[3];
      default: rd_mux_w = '0;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (clk_en_i) begin
      rdata_o <= rd_i ? rd_mux_w : '0;
    end
  end

  // ********************************************************
  // Registered clock outputs
  // ********************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      osc_lock_o <= 1'b0;
      clk_path_sdd_o <= 1'b0;
      sdd_factor_o <= RST_SDD_FACTOR;
      osc_supervision_o <= 1'b0;
      cpu_halt_o <= 1'b0;
    end else if (clk_en_i) begin
      osc_lock_o <= lock_q;
      clk_path_sdd_o <= path_q[0] | halt_q; // Path lags halt [R8]
      sdd_factor_o <= fact_q;
      osc_supervision_o <= lock_q & ~halt_q; // [R8]
      cpu_halt_o <= halt_q;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  a_flag_sampled: assert property (@(posedge core_clk_i) disable iff (rst_i)
    release_w |=> por_flag_q == $past(por_filt_q)) // [R9]
    else $error("power-on flag not taken at release");
  a_flag_readback: assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i && rd_i && addr_i == A_STATUS
    |=> rdata_o[ST_POR_FLAG] == por_flag_q) // [R1]
    else $error("status read does not show power-on flag");
  a_lock_count: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(lock_q) |-> lock_cnt_q == LOCK_CYCLES && por_flag_q) // [R2]
    else $error("lock rose without full period count");
  a_rtc_cleared: assert property (@(posedge core_clk_i) disable iff (rst_i)
    release_w && por_filt_q
    |=> rtc_q[0] == RTC_CLEAR && rtc_q[1] == RTC_CLEAR &&
        rtc_q[2] == RTC_CLEAR && rtc_q[3] == RTC_CLEAR) // [R3]
    else $error("rtc registers not cleared after power-on");
  a_sdd_entry: assert property (@(posedge core_clk_i) disable iff (rst_i)
    path_q == PS_BASIC && wr_ctrl_w && wdata_i[CTRL_SDD_SEL]
    |=> ##1 clk_path_sdd_o) // [R4]
    else $error("divider request from basic path not taken");
  a_return_lock: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $past(path_q) == PS_RETURN && path_q == PS_BASIC
    |-> $past(lock_q)) // [R5]
    else $error("returned to basic path without lock");
  a_fail_nolock: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !por_flag_q |-> !lock_q && !osc_lock_o) // [R6]
    else $error("lock set without detected power-on");
  a_halt_sdd: assert property (@(posedge core_clk_i) disable iff (rst_i)
    cpu_halt_o |-> clk_path_sdd_o && !osc_supervision_o) // [R8]
    else $error("halt without divider path or with supervision");

endmodule
`default_nettype wire

// *** test_power_on_clock_config.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_power_on_clock_config;
  import pcc_pkg::*;

  // ********************************************************
  // Stimulus signals
  // ********************************************************
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic por_detect_i = 1'b1;
  logic osc_present_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 8'h00;
  logic [DATA_W-1:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic irq_o;
  logic osc_lock_o;
  logic clk_path_sdd_o;
  logic [FACT_W-1:0] sdd_factor_o;
  logic osc_supervision_o;
  logic cpu_halt_o;
  int errors = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [ADDR_W-1:0] row_a [9];
  logic [DATA_W-1:0] row_e [9];

  pcc_top pcc_top_inst (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .clk_en_i(clk_en_i),
    .por_detect_i(por_detect_i),
    .osc_present_i(osc_present_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .irq_o(irq_o),
    .osc_lock_o(osc_lock_o),
    .clk_path_sdd_o(clk_path_sdd_o),
    .sdd_factor_o(sdd_factor_o),
    .osc_supervision_o(osc_supervision_o),
    .cpu_halt_o(cpu_halt_o)
  );

  // ********************************************************
  // Clock and cycle count since reset release
  // ********************************************************
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Counts edges from the release edge, which sets it to one
  always @(posedge core_clk_i) begin
    if (rst_i) cyc <= 0;
    else cyc <= cyc + 1;
  end

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic edges(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wait_cyc(input int n);
    while (cyc < n) @(posedge core_clk_i);
    #1;
  endtask

  // Strobe lowered on the next edge, so back-to-back calls are safe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Detector and oscillator levels are set well before release
  task automatic do_reset(input logic por, input logic osc);
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    por_detect_i <= por;
    osc_present_i <= osc;
    edges(19);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin : main
    logic [31:0] d;
    row_a = '{A_CTRL, A_STATUS, A_IRQ_STAT, A_IRQ_MASK, A_RTC_TIMER,
              A_RTC_RELOAD, A_RTC_HIGH, A_RTC_LOW, 8'h20};
    row_e = '{32'h10, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
              32'h0};
    edges(19);
    check({osc_lock_o, clk_path_sdd_o, irq_o, cpu_halt_o}, 32'h0);
    check(sdd_factor_o, 32'h1);
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    edges(2);
    // Detector result changes after release and must not matter
    @(posedge core_clk_i);
    por_detect_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(row_a[i], d);
      check(d, row_e[i]);
    end
    // Read data stand one cycle only
    edges(1);
    check(rdata_o, 32'h0);
    // Onto the divider, then a return request before lock
    wr(A_CTRL, 32'h11);
    edges(1);
    check(clk_path_sdd_o, 32'h1);
    wr(A_CTRL, 32'h10);
    rd(A_STATUS, d);
    check(d, 32'hd);
    wait_cyc(2045);
    check(osc_lock_o, 32'h0);
    check(clk_path_sdd_o, 32'h1);
    wait_cyc(2056);
    check(osc_lock_o, 32'h1);
    check(osc_supervision_o, 32'h1);
    check(clk_path_sdd_o, 32'h0);
    rd(A_STATUS, d);
    check(d, 32'h3);
    rd(A_IRQ_STAT, d);
    check(d, 32'h3);
    // Mask, raise and clear the interrupt line
    check(irq_o, 32'h0);
    wr(A_IRQ_MASK, 32'h1);
    edges(1);
    check(irq_o, 32'h1);
    wr(A_IRQ_STAT, 32'h1);
    edges(1);
    check(irq_o, 32'h0);
    wr(A_IRQ_MASK, 32'h3);
    edges(1);
    check(irq_o, 32'h1);
    wr(A_IRQ_STAT, 32'h2);
    edges(1);
    check(irq_o, 32'h0);
    wr(A_CTRL, 32'h21);
    edges(1);
    check(sdd_factor_o, 32'h2);
    // Enable low: the write below must not land
    @(posedge core_clk_i);
    clk_en_i <= 1'b0;
    wr(A_CTRL, 32'h30);
    edges(2);
    @(posedge core_clk_i);
    clk_en_i <= 1'b1;
    edges(1);
    check(sdd_factor_o, 32'h2);
    // Value that only a detected power-on may clear
    wr(A_RTC_LOW, 32'h5a5a);
    // Failed detection with a running oscillator
    do_reset(1'b0, 1'b1);
    wr(A_CTRL, 32'h01);
    wr(A_CTRL, 32'h00);
    wait_cyc(2100);
    check(osc_lock_o, 32'h0);
    check(clk_path_sdd_o, 32'h1);
    rd(A_STATUS, d);
    check(d, 32'hc);
    rd(A_RTC_LOW, d);
    check(d, 32'h5a5a);
    // Failed detection and no oscillator: forced divider, halted
    do_reset(1'b0, 1'b0);
    wr(A_CTRL, 32'h00);
    wait_cyc(10);
    check({cpu_halt_o, clk_path_sdd_o, osc_supervision_o}, 32'h6);
    rd(A_STATUS, d);
    check(d, 32'h14);
    rd(A_IRQ_STAT, d);
    check(d, 32'h4);
    rd(A_RTC_LOW, d);
    check(d, 32'h5a5a);
    // Detected power-on again clears the held value
    do_reset(1'b1, 1'b1);
    rd(A_RTC_LOW, d);
    check(d, 32'h0);
    rd(A_STATUS, d);
    check(d, 32'h1);
    end_of_test();
  end

  // ********************************************************
  // Watchdog: the sequence needs some 4300 cycles
  // ********************************************************
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
